/* ccpu_unit.sv */
// Capture/compare/PWM unit pair with its register file
`timescale 1ns/1ps
module ccpu_unit (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ccpu_pkg::CCPU_AW-1:0] reg_addr,
  input wire logic [ccpu_pkg::CCPU_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ccpu_pkg::CCPU_DW-1:0] reg_rdata,
  input wire logic [15:0] timer1_count,
  input wire logic [7:0] timer2_count,
  input wire logic [1:0] timer2_fine,
  input wire logic timer2_period_done,
  input wire logic adc_enabled,
  input wire logic [ccpu_pkg::CCPU_UNITS-1:0] unit_pin_in,
  output logic [ccpu_pkg::CCPU_UNITS-1:0] unit_pin_out,
  output logic [ccpu_pkg::CCPU_UNITS-1:0] unit_pin_oe,
  output logic timer1_reset,
  output logic adc_start,
  output logic [ccpu_pkg::CCPU_UNITS-1:0] unit_flag,
  output logic [ccpu_pkg::CCPU_UNITS-1:0] unit_irq_enable
);
  import ccpu_pkg::*;

  // ---------------------------------------------------------------
  // Per-unit state
  // ---------------------------------------------------------------
  logic [7:0] ctrl [CCPU_UNITS];
  logic [7:0] data_lo [CCPU_UNITS];
  logic [7:0] data_hi [CCPU_UNITS];
  logic [1:0] duty_latch [CCPU_UNITS];
  logic [3:0] presc_cnt [CCPU_UNITS];
  logic [CCPU_UNITS-1:0] pin_prev;
  logic [CCPU_UNITS-1:0] match_prev;
  logic [CCPU_UNITS-1:0] special;
  logic [CCPU_UNITS-1:0] sel_flag;
  logic [CCPU_UNITS-1:0] sel_ie;
  logic [CCPU_UNITS-1:0] sel_lo;
  logic [CCPU_UNITS-1:0] sel_hi;
  logic [CCPU_UNITS-1:0] sel_ctrl;
  logic [CCPU_DW-1:0] next_rdata;

  genvar i;
  generate
    for (i = 0; i < CCPU_UNITS; i++) begin : g_unit
      wire [3:0] mode = ctrl[i][3:0];
      wire [3:0] new_mode = reg_wdata[3:0];
      wire is_cap = mode[3:2] == CCPU_GRP_CAP;
      wire is_cmp = mode[3:2] == CCPU_GRP_CMP;
      wire is_pwm = mode[3:2] == CCPU_GRP_PWM;
      wire rise = unit_pin_in[i] & ~pin_prev[i];
      wire fall = ~unit_pin_in[i] & pin_prev[i];
      wire wr_flag = reg_wr && sel_flag[i];
      wire wr_ie = reg_wr && sel_ie[i];
      wire wr_lo = reg_wr && sel_lo[i];
      wire wr_hi = reg_wr && sel_hi[i] && !is_pwm;
      wire wr_ctrl = reg_wr && sel_ctrl[i];
      // Capture event selection per prescale setting
      wire cap_evt = is_cap && ((mode == CCPU_MODE_CAP_FALL && fall)
        || (mode == CCPU_MODE_CAP_RISE && rise)
        || (mode == CCPU_MODE_CAP_RISE4 && rise && presc_cnt[i][1:0] == CCPU_PRESC_LAST4[1:0])
        || (mode == CCPU_MODE_CAP_RISE16 && rise && presc_cnt[i] == CCPU_PRESC_LAST16));
      // Switching straight between two capture settings leaves a stale edge count
      wire spurious = wr_ctrl && is_cap && new_mode[3:2] == CCPU_GRP_CAP
        && new_mode != mode;
      // Edge-of-match so a stalled timer 1 fires only once
      wire match = timer1_count == {data_hi[i], data_lo[i]};
      wire cmp_evt = is_cmp && match && !match_prev[i];
      wire [9:0] next_duty = {data_lo[i], ctrl[i][CCPU_DUTY_LSB+1:CCPU_DUTY_LSB]};
      // Longer duty than period never meets the counter, so the pin stays high
      wire duty_hit = {data_hi[i], duty_latch[i]} == {timer2_count, timer2_fine};
      wire set_flag = cap_evt || cmp_evt || spurious;
      wire pin_oe = is_cmp || is_pwm;

      assign special[i] = cmp_evt && mode == CCPU_MODE_CMP_SPECIAL;
      assign unit_pin_oe[i] = pin_oe;

      // -----------------------------------------------------------
      // Control and enable
      // -----------------------------------------------------------
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          ctrl[i] <= CCPU_CTRL_RST;
          unit_irq_enable[i] <= 1'b0;
        end else begin
          if (wr_ctrl) begin
            ctrl[i] <= reg_wdata & CCPU_CTRL_MASK;
          end
          if (wr_ie) begin
            unit_irq_enable[i] <= reg_wdata[CCPU_FLAG_BIT[i]];
          end
        end
      end

      // Hardware set wins over a software clear in the same cycle
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          unit_flag[i] <= 1'b0;
        end else if (set_flag) begin
          unit_flag[i] <= 1'b1;
        end else if (wr_flag) begin
          unit_flag[i] <= reg_wdata[CCPU_FLAG_BIT[i]];
        end
      end

      // -----------------------------------------------------------
      // Edge sampling and capture prescaler
      // -----------------------------------------------------------
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          pin_prev[i] <= 1'b0;
          match_prev[i] <= 1'b0;
          presc_cnt[i] <= 4'h0;
        end else begin
          pin_prev[i] <= unit_pin_in[i];
          match_prev[i] <= match;
          if (!is_cap) begin
            presc_cnt[i] <= 4'h0;
          end else if (rise) begin
            presc_cnt[i] <= presc_cnt[i] + 4'h1;
          end
        end
      end

      // -----------------------------------------------------------
      // Data word: capture, software, PWM reload
      // -----------------------------------------------------------
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          data_lo[i] <= CCPU_DATA_RST;
          data_hi[i] <= CCPU_DATA_RST;
          duty_latch[i] <= 2'h0;
        end else if (cap_evt) begin
          data_lo[i] <= timer1_count[7:0];
          data_hi[i] <= timer1_count[15:8];
        end else begin
          if (wr_lo) begin
            data_lo[i] <= reg_wdata;
          end
          if (wr_hi) begin
            data_hi[i] <= reg_wdata;
          end
          // Postscaler plays no part: reload follows the raw period end
          if (is_pwm && timer2_period_done) begin
            data_hi[i] <= next_duty[9:2];
            duty_latch[i] <= next_duty[1:0];
          end
        end
      end

      // -----------------------------------------------------------
      // Output latch shared by compare and PWM
      // -----------------------------------------------------------
      always_ff @(posedge ref_clk) begin
        if (rst || mode == CCPU_MODE_OFF) begin
          unit_pin_out[i] <= 1'b0;
        end else if (is_cmp && cmp_evt) begin
          if (mode == CCPU_MODE_CMP_SET) begin
            unit_pin_out[i] <= 1'b1;
          end else if (mode == CCPU_MODE_CMP_CLR) begin
            unit_pin_out[i] <= 1'b0;
          end
        end else if (is_pwm && timer2_period_done) begin
          unit_pin_out[i] <= next_duty != 10'h000;
        end else if (is_pwm && duty_hit) begin
          unit_pin_out[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Triggers toward timer 1 and the converter
  // ---------------------------------------------------------------
  // A dedicated reset line keeps timer 1 from seeing an overflow
  assign timer1_reset = |special;
  assign adc_start = special[CCPU_ADC_UNIT] && adc_enabled;

  // ---------------------------------------------------------------
  // Register decode and read-back
  // ---------------------------------------------------------------
  generate
    for (i = 0; i < CCPU_UNITS; i++) begin : g_dec
      assign sel_flag[i] = reg_addr == CCPU_FLAG_OFS[i];
      assign sel_ie[i] = reg_addr == CCPU_IE_OFS[i];
      assign sel_lo[i] = reg_addr == CCPU_DATA_LO_OFS[i];
      assign sel_hi[i] = reg_addr == CCPU_DATA_HI_OFS[i];
      assign sel_ctrl[i] = reg_addr == CCPU_CTRL_OFS[i];
    end
  endgenerate

  // Other peripherals own the rest of the flag and enable bytes
  always_comb begin
    next_rdata = 8'h00;
    for (int u = 0; u < CCPU_UNITS; u++) begin
      if (sel_flag[u]) next_rdata[CCPU_FLAG_BIT[u]] = unit_flag[u];
      if (sel_ie[u]) next_rdata[CCPU_FLAG_BIT[u]] = unit_irq_enable[u];
      if (sel_lo[u]) next_rdata = data_lo[u];
      if (sel_hi[u]) next_rdata = data_hi[u];
      if (sel_ctrl[u]) next_rdata = ctrl[u];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : ccpu_unit

/* ccpu_pkg.sv */
// Constants shared by the capture/compare/PWM unit pair
package ccpu_pkg;
  localparam int CCPU_UNITS = 2;
  localparam int CCPU_AW = 8;
  localparam int CCPU_DW = 8;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CCPU_FLAGS1_OFS = 8'h0C;
  localparam logic [7:0] CCPU_FLAGS2_OFS = 8'h0D;
  localparam logic [7:0] CCPU_ENABLES1_OFS = 8'h8C;
  localparam logic [7:0] CCPU_ENABLES2_OFS = 8'h8D;
  localparam logic [7:0] CCPU_DATA_LO_OFS [CCPU_UNITS] = '{8'h15, 8'h1B};
  localparam logic [7:0] CCPU_DATA_HI_OFS [CCPU_UNITS] = '{8'h16, 8'h1C};
  localparam logic [7:0] CCPU_CTRL_OFS [CCPU_UNITS] = '{8'h17, 8'h1D};
  localparam logic [7:0] CCPU_FLAG_OFS [CCPU_UNITS] = '{8'h0C, 8'h0D};
  localparam logic [7:0] CCPU_IE_OFS [CCPU_UNITS] = '{8'h8C, 8'h8D};
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CCPU_FLAG_BIT [CCPU_UNITS] = '{2, 0};
  localparam int CCPU_DUTY_LSB = 4;
  localparam logic [7:0] CCPU_CTRL_RST = 8'h00;
  localparam logic [7:0] CCPU_CTRL_MASK = 8'h3F;
  localparam logic [7:0] CCPU_DATA_RST = 8'h00;
  // ---------------------------------------------------------------
  // Mode field encodings
  // ---------------------------------------------------------------
  localparam logic [3:0] CCPU_MODE_OFF = 4'h0;
  localparam logic [3:0] CCPU_MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] CCPU_MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] CCPU_MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] CCPU_MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] CCPU_MODE_CMP_SET = 4'h8;
  localparam logic [3:0] CCPU_MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] CCPU_MODE_CMP_SOFT = 4'hA;
  localparam logic [3:0] CCPU_MODE_CMP_SPECIAL = 4'hB;
  localparam logic [1:0] CCPU_GRP_CAP = 2'h1;
  localparam logic [1:0] CCPU_GRP_CMP = 2'h2;
  localparam logic [1:0] CCPU_GRP_PWM = 2'h3;
  localparam logic [3:0] CCPU_PRESC_LAST4 = 4'h3;
  localparam logic [3:0] CCPU_PRESC_LAST16 = 4'hF;
  localparam int CCPU_ADC_UNIT = 1;
endpackage : ccpu_pkg

/* ccpu_unit_sva.sv */
// Port-level checker for the unit pair
`timescale 1ns/1ps
module ccpu_unit_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic adc_enabled,
  input wire logic [1:0] unit_pin_out,
  input wire logic [1:0] unit_pin_oe,
  input wire logic timer1_reset,
  input wire logic adc_start,
  input wire logic [1:0] unit_flag,
  input wire logic [1:0] unit_irq_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_adc_pair; adc_start |-> timer1_reset && adc_enabled; endproperty
  a_adc_pair: assert property (p_adc_pair)
    else $error("conversion start without trigger");
  property p_trig_once; timer1_reset |=> !timer1_reset; endproperty
  a_trig_once: assert property (p_trig_once)
    else $error("trigger longer than one cycle");
  property p_trig_flag; timer1_reset |=> (unit_flag != 2'h0); endproperty
  a_trig_flag: assert property (p_trig_flag)
    else $error("match without flag");
  property p_adc_flag; adc_start |=> unit_flag[1]; endproperty
  a_adc_flag: assert property (p_adc_flag)
    else $error("unit 2 flag missing");
  property p_rd_ctrl; $past(reg_rd && reg_addr == 8'h17) |-> reg_rdata[7:6] == 2'h0; endproperty
  a_rd_ctrl: assert property (p_rd_ctrl)
    else $error("control top bits not zero");
  property p_off; reg_wr && reg_addr == 8'h17 && reg_wdata[3:0] == 4'h0 |=> !unit_pin_oe[0] ##1 !unit_pin_out[0];
  endproperty
  a_off: assert property (p_off)
    else $error("off did not clear latch");
  property p_flag_sw; $fell(unit_flag[0]) |-> $past(reg_wr && reg_addr == 8'h0C && !reg_wdata[2]); endproperty
  a_flag_sw: assert property (p_flag_sw)
    else $error("flag fell without clear");
  property p_ie; reg_wr && reg_addr == 8'h8D |=> unit_irq_enable[1] == $past(reg_wdata[0]); endproperty
  a_ie: assert property (p_ie)
    else $error("enable bit not stored");
  c_trig: cover property (timer1_reset);
  c_adc: cover property (adc_start);
  c_pwm: cover property ($rose(unit_pin_out[0]) && unit_pin_oe[0]);
endmodule : ccpu_unit_chk
bind ccpu_unit ccpu_unit_chk u_chk (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .adc_enabled, .unit_pin_out, .unit_pin_oe, .timer1_reset, .adc_start, .unit_flag, .unit_irq_enable);

/* ccpu_pin_src.sv */
// Outside signal source standing on the two unit pins
`timescale 1ns/1ps
module ccpu_pin_src (
  input wire logic [1:0] src_lvl,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pin_in
);
  // The unit wins while it drives; else the source sets the level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & src_lvl);
endmodule : ccpu_pin_src

/* ccpu_unit_tb_top.sv */
// Self-checking bench for the unit pair
`timescale 1ns/1ps
module ccpu_unit_tb_top;
  import ccpu_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] timer1_count = 16'h0000;
  logic [7:0] timer2_count = 8'h00;
  logic [1:0] timer2_fine = 2'h0;
  logic timer2_period_done = 1'b0;
  logic adc_enabled = 1'b0;
  logic [1:0] src_lvl = 2'h0;
  logic [7:0] reg_rdata;
  logic [1:0] pin_in, pin_out, pin_oe, unit_flag, unit_irq_enable;
  logic timer1_reset, adc_start;
  int error_cnt = 0;
  int tests_run = 0;
  always #25 ref_clk = ~ref_clk;
  ccpu_unit DUT (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timer1_count,
    .timer2_count, .timer2_fine, .timer2_period_done, .adc_enabled, .unit_pin_in(pin_in),
    .unit_pin_out(pin_out), .unit_pin_oe(pin_oe), .timer1_reset, .adc_start, .unit_flag, .unit_irq_enable);
  ccpu_pin_src u_src (.src_lvl, .pin_out, .pin_oe, .pin_in);
  // -----------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd
  task automatic wrap;
    @(posedge ref_clk);
    timer2_count <= 8'h00;
    timer2_fine <= 2'h0;
    timer2_period_done <= 1'b1;
    @(posedge ref_clk);
    timer2_period_done <= 1'b0;
    #1;
  endtask : wrap
  // -----------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------
  task automatic t_regs;
    rd(8'h17, 8'h00);
    wr(8'h17, 8'hFF);
    rd(8'h17, 8'h3F);
    wr(8'h40, 8'h5A);
    rd(8'h40, 8'h00);
    wr(8'h8C, 8'h04);
    wr(8'h8D, 8'h01);
    #1;
    chk(unit_irq_enable, 2'h3);
    for (int m = 0; m < 16; m++) begin
      wr(8'h1D, 8'(m));
      rd(8'h1D, 8'(m));
      if (m == 5) chk(unit_flag[1], 1'b1);
    end
    wr(8'h17, 8'h00);
    wr(8'h1D, 8'h00);
    wr(8'h0D, 8'h00);
  endtask : t_regs
  task automatic t_capture;
    wr(8'h17, 8'h05);
    @(posedge ref_clk);
    timer1_count <= 16'hBEEF;
    src_lvl[0] <= 1'b1;
    cyc(2);
    rd(8'h0C, 8'h04);
    rd(8'h15, 8'hEF);
    rd(8'h16, 8'hBE);
    wr(8'h1D, 8'h06);
    // Off before the prescaled mode, so the count starts at zero
    repeat (4) begin
      chk(unit_flag[1], 1'b0);
      @(posedge ref_clk);
      src_lvl[1] <= 1'b1;
      @(posedge ref_clk);
      src_lvl[1] <= 1'b0;
      cyc(2);
    end
    chk(unit_flag[1], 1'b1);
    wr(8'h17, 8'h00);
    wr(8'h1D, 8'h00);
    wr(8'h0C, 8'h00);
    wr(8'h0D, 8'h00);
  endtask : t_capture
  task automatic t_compare;
    wr(8'h15, 8'h34);
    wr(8'h16, 8'h12);
    wr(8'h17, 8'h08);
    @(posedge ref_clk);
    timer1_count <= 16'h1234;
    cyc(1);
    chk({pin_oe[0], pin_out[0], unit_flag[0]}, 3'h7);
    wr(8'h0C, 8'h00);
    wr(8'h17, 8'h0A);
    @(posedge ref_clk);
    timer1_count <= 16'h0000;
    @(posedge ref_clk);
    timer1_count <= 16'h1234;
    cyc(1);
    chk({pin_out[0], unit_flag[0]}, 2'h3);
    wr(8'h17, 8'h00);
    cyc(1);
    chk({pin_oe[0], pin_out[0]}, 2'h0);
  endtask : t_compare
  task automatic t_special;
    wr(8'h1B, 8'h40);
    wr(8'h1C, 8'h00);
    adc_enabled <= 1'b1;
    wr(8'h1D, 8'h0B);
    @(posedge ref_clk);
    timer1_count <= 16'h0040;
    #1;
    chk({timer1_reset, adc_start}, 2'h3);
    cyc(1);
    chk({timer1_reset, unit_flag[1]}, 2'h1);
    wr(8'h1D, 8'h00);
    wr(8'h0D, 8'h00);
  endtask : t_special
  task automatic t_pwm;
    wr(8'h15, 8'h29);
    wr(8'h17, 8'h1C);
    wrap;
    chk({pin_oe[0], pin_out[0]}, 2'h3);
    wr(8'h16, 8'hFF);
    rd(8'h16, 8'h29);
    wr(8'h15, 8'h00);
    chk(pin_out[0], 1'b1);
    @(posedge ref_clk);
    timer2_count <= 8'h29;
    timer2_fine <= 2'h1;
    cyc(1);
    chk(pin_out[0], 1'b0);
    wr(8'h17, 8'h0C);
    wrap;
    chk(pin_out[0], 1'b0);
    wr(8'h17, 8'h00);
    cyc(1);
    chk(pin_oe[0], 1'b0);
  endtask : t_pwm
  task automatic end_sim;
    $display("error_cnt=%0d tests_run=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_capture;
    t_compare;
    t_special;
    t_pwm;
    end_sim;
  end
  // Run needs under a thousand cycles; this cuts a hang short
  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    end_sim;
  end
endmodule : ccpu_unit_tb_top
